// File: slh_pkg.sv
// Package for the stop exit and limp-home sequencer.
// Assumes a single 250 MHz clock and AXI4-Lite register access.
package slh_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SLH_CTRL_OFS = 8'h00;
	localparam logic [7:0] SLH_FLAGS_OFS = 8'h04;
	localparam logic [7:0] SLH_STAT_OFS = 8'h08;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int SLH_CTRL_NOLIMP_BIT = 0;
	localparam int SLH_CTRL_MON_BIT = 1;
	localparam int SLH_CTRL_FMON_BIT = 2;
	localparam int SLH_CTRL_DELAY_BIT = 3;
	localparam int SLH_CTRL_PSTOP_BIT = 4;
	localparam int SLH_CTRL_INTEN_BIT = 5;
	localparam int SLH_CTRL_BUSSEL_BIT = 6;
	localparam int SLH_CTRL_MODSEL_BIT = 7;
	localparam logic [7:0] SLH_CTRL_RESET = 8'h0a;

	// ----------------------------------------
	// Flags and status fields
	// ----------------------------------------
	localparam int SLH_FLG_STATUS_BIT = 0;
	localparam int SLH_FLG_INTFLAG_BIT = 1;
	localparam int SLH_STAT_STOPPED_BIT = 0;
	localparam int SLH_STAT_WAITING_BIT = 1;
	localparam int SLH_STAT_PSEUDO_BIT = 2;

	// ----------------------------------------
	// Counter timing in slow-divided clock cycles
	// ----------------------------------------
	localparam int SLH_CNT_STAGES = 13;
	localparam logic [12:0] SLH_MID_COUNT = 13'h1000;
	localparam logic [12:0] SLH_SHORT_COUNT = 13'h0010;

	localparam logic [1:0] SLH_RESP_OKAY = 2'h0;
	localparam logic [1:0] SLH_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SLH_RUN,
		SLH_STOPPED,
		SLH_DELAY,
		SLH_LIMP
	} slh_state_t;

endpackage

// File: slh_sequencer.sv
// Stop and pseudo-stop exit sequencer with limp-home clock fallback.
// Assumes wake inputs and the clock-present level come from pins.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps

// Operation
// - Stop instruction enters stop; recovery chosen by limp disable, monitor, delay bits.
// - Delay enable set gives a 4096-count wait from the 13-stage counter.
// - Counter advances only on slow-divided clock enables.
// - Reset, irq, nonmaskable_irq_pin, key wake-ups or can wake-up exit stop.
// - Limp disabled, monitor off: exit on oscillator clock, 4096 cycles with delay.
// - Limp disabled, monitor enabled: stop instruction causes clock monitor reset.
// - Limp enabled: monitors masked at stop; exit in limp-home with monitors on.
// - Limp plus delay: after 4096 cycles, clock present ends limp-home.
// - No clock after 4096: limp status and flag set; recheck every 8192.
// - Clock found in limp-home: clear status, set flag, interrupt if enabled.
// - Leaving limp-home restores bus and module clock selects.
// - Limp enabled, no delay, no clock present: release at once and run in limp-home.
// - Clock present with no delay: release at once, limp status never set.
// - Pseudo-stop select makes stop keep oscillator running; same wakes, delay.
// - Pseudo-stop exit with limp and delay enters limp-home; selects forced.
// - Pseudo-stop exit with limp and no delay releases without delay.
// - Pseudo-stop, limp off, monitor off, delay: external clock after 4096.
// - Pseudo-stop, limp off, monitor off, no delay: external clock after 16.
// - Limp flag clears only when software writes one to it.
module slh_sequencer
	import slh_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Slow-divided clock enable pulse
	input wire logic slow_divided_clock,
	// Core stop request
	input wire logic stop_exec,
	// Wake sources and oscillator status (asynchronous)
	input wire logic ext_reset_wake,
	input wire logic irq_wake,
	input wire logic nonmaskable_irq_pin,
	input wire logic key_wake_j,
	input wire logic key_wake_h,
	input wire logic can_controller_wakeup,
	input wire logic ext_clock_present,
	// Sequencer outputs
	output logic core_release,
	output logic core_clock_source,
	output logic osc_enable,
	output logic clock_monitor_reset,
	output logic monitor_active,
	output logic pll_bus_clock_select,
	output logic module_clock_select,
	output logic limp_home_irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [6:0] sync1;
	logic [6:0] sync2;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
		end else begin
			sync1 <= {ext_clock_present, can_controller_wakeup, key_wake_h, key_wake_j,
				nonmaskable_irq_pin, irq_wake, ext_reset_wake};
			sync2 <= sync1;
		end
	end
	logic wake_any;
	logic clk_seen;
	assign wake_any = |sync2[5:0];
	assign clk_seen = sync2[6];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] ctrl;
	logic limp_home_status;
	logic limp_home_int_flag;
	logic limp_home_disable;
	logic clock_monitor_enable;
	logic forced_clock_monitor_enable;
	logic stop_exit_delay_enable;
	logic pseudo_stop_select;
	logic limp_home_int_enable;
	assign limp_home_disable = ctrl[SLH_CTRL_NOLIMP_BIT];
	assign clock_monitor_enable = ctrl[SLH_CTRL_MON_BIT];
	assign forced_clock_monitor_enable = ctrl[SLH_CTRL_FMON_BIT];
	assign stop_exit_delay_enable = ctrl[SLH_CTRL_DELAY_BIT];
	assign pseudo_stop_select = ctrl[SLH_CTRL_PSTOP_BIT];
	assign limp_home_int_enable = ctrl[SLH_CTRL_INTEN_BIT];

	// ----------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SLH_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] == SLH_CTRL_OFS[7:2] ||
					aw_addr[7:2] == SLH_FLAGS_OFS[7:2] ||
					aw_addr[7:2] == SLH_STAT_OFS[7:2]) ? SLH_RESP_OKAY : SLH_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic ctrl_wr;
	logic flag_clr;
	assign ctrl_wr = wr_fire && aw_addr[7:2] == SLH_CTRL_OFS[7:2] && w_strb[0];
	assign flag_clr = wr_fire && aw_addr[7:2] == SLH_FLAGS_OFS[7:2] && w_strb[0] &&
		w_data[SLH_FLG_INTFLAG_BIT];

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	slh_state_t state;
	logic [SLH_CNT_STAGES-1:0] cnt;
	logic pseudo;
	logic saved_bus_sel;
	logic saved_mod_sel;
	logic mid_hit;
	logic short_mode;
	logic lh_set;
	logic lh_event;
	assign mid_hit = slow_divided_clock && (cnt == SLH_MID_COUNT - 13'h1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= SLH_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl <= w_data[7:0];
		end
	end

	// Counter free-runs in limp-home, cleared at each delay start
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (state == SLH_STOPPED || state == SLH_RUN) begin
			cnt <= '0;
		end else if (slow_divided_clock) begin
			cnt <= cnt + 13'h1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= SLH_RUN;
			pseudo <= 1'b0;
			short_mode <= 1'b0;
			limp_home_status <= 1'b0;
			lh_event <= 1'b0;
			clock_monitor_reset <= 1'b0;
			saved_bus_sel <= 1'b0;
			saved_mod_sel <= 1'b0;
		end else begin
			lh_event <= 1'b0;
			clock_monitor_reset <= 1'b0;
			case (state)
				SLH_RUN: begin
					if (stop_exec) begin
						if (limp_home_disable &&
							(clock_monitor_enable || forced_clock_monitor_enable)) begin
							clock_monitor_reset <= 1'b1;
						end else begin
							state <= SLH_STOPPED;
							pseudo <= pseudo_stop_select;
							saved_bus_sel <= ctrl[SLH_CTRL_BUSSEL_BIT];
							saved_mod_sel <= ctrl[SLH_CTRL_MODSEL_BIT];
						end
					end
				end
				SLH_STOPPED: begin
					if (wake_any) begin
						short_mode <= 1'b0;
						if (limp_home_disable) begin
							if (stop_exit_delay_enable) begin
								state <= SLH_DELAY;
							end else if (pseudo) begin
								state <= SLH_DELAY;
								short_mode <= 1'b1;
							end else begin
								state <= SLH_RUN;
							end
						end else if (stop_exit_delay_enable) begin
							state <= SLH_DELAY;
						end else if (clk_seen) begin
							state <= SLH_RUN;
						end else begin
							state <= SLH_LIMP;
							limp_home_status <= 1'b1;
							lh_event <= 1'b1;
						end
					end
				end
				SLH_DELAY: begin
					if (short_mode) begin
						if (slow_divided_clock && cnt == SLH_SHORT_COUNT - 13'h1) begin
							state <= SLH_RUN;
						end
					end else if (mid_hit) begin
						if (limp_home_disable || clk_seen) begin
							state <= SLH_RUN;
						end else begin
							state <= SLH_LIMP;
							limp_home_status <= 1'b1;
							lh_event <= 1'b1;
						end
					end
				end
				SLH_LIMP: begin
					if (mid_hit && clk_seen) begin
						state <= SLH_RUN;
						limp_home_status <= 1'b0;
						lh_event <= 1'b1;
					end
				end
				default: state <= SLH_RUN;
			endcase
		end
	end

	// Flag set wins over a simultaneous clear
	assign lh_set = lh_event;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			limp_home_int_flag <= 1'b0;
		end else if (lh_set) begin
			limp_home_int_flag <= 1'b1;
		end else if (flag_clr) begin
			limp_home_int_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Clock selection outputs
	// ----------------------------------------
	logic limp_clk;
	assign limp_clk = !limp_home_disable &&
		(state == SLH_LIMP || (state == SLH_DELAY && !short_mode));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_release <= 1'b1;
			core_clock_source <= 1'b0;
			osc_enable <= 1'b1;
			monitor_active <= 1'b0;
			pll_bus_clock_select <= 1'b0;
			module_clock_select <= 1'b0;
			limp_home_irq <= 1'b0;
		end else begin
			core_release <= state == SLH_RUN || state == SLH_LIMP;
			core_clock_source <= limp_clk;
			osc_enable <= state != SLH_STOPPED || pseudo;
			monitor_active <= limp_clk ||
				(state != SLH_STOPPED && (clock_monitor_enable ||
				forced_clock_monitor_enable));
			pll_bus_clock_select <= limp_clk ? 1'b1 : (state == SLH_RUN ?
				ctrl[SLH_CTRL_BUSSEL_BIT] : saved_bus_sel);
			module_clock_select <= limp_clk ? 1'b0 : (state == SLH_RUN ?
				ctrl[SLH_CTRL_MODSEL_BIT] : saved_mod_sel);
			limp_home_irq <= limp_home_int_flag && limp_home_int_enable;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= SLH_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= SLH_RESP_OKAY;
			case (s_axi_araddr[7:2])
				SLH_CTRL_OFS[7:2]: s_axi_rdata <= {24'h0, ctrl};
				SLH_FLAGS_OFS[7:2]: s_axi_rdata <= {30'h0, limp_home_int_flag,
					limp_home_status};
				SLH_STAT_OFS[7:2]: s_axi_rdata <= {29'h0, pseudo,
					state == SLH_DELAY, state == SLH_STOPPED};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= SLH_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: slh_sequencer_chk.sv
// Concurrent checks on the stop exit sequencer outputs.
// Assumes binding onto slh_sequencer, single clock domain.
`timescale 1ns/10ps
module slh_sequencer_chk
	import slh_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Sequencer outputs
	input wire logic core_release,
	input wire logic core_clock_source,
	input wire logic osc_enable,
	input wire logic clock_monitor_reset,
	input wire logic monitor_active,
	input wire logic pll_bus_clock_select,
	input wire logic module_clock_select,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_cmr_single: assert property (
		clock_monitor_reset |=> !clock_monitor_reset) else $error("monitor reset too long");
	a_limp_forced: assert property (
		core_clock_source |-> pll_bus_clock_select && !module_clock_select)
		else $error("selects not forced in limp");
	a_limp_monitor: assert property (
		core_clock_source |-> monitor_active) else $error("monitor off in limp");
	a_osc_core: assert property (
		!osc_enable |-> !core_release) else $error("core runs with osc off");
	a_stop_hold: assert property (
		$fell(core_release) |=> !core_release [*2]) else $error("stop too short");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("no write response");
	a_write_done: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response held");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
endmodule

bind slh_sequencer slh_sequencer_chk i_slh_sequencer_chk (.*);

// File: slh_wake_model.sv
// Wake sources and slow-divided clock enable seen by the sequencer.
// Assumes the bench selects which wake line to raise.
`timescale 1ns/10ps
module slh_wake_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bench control
	input wire logic wake_on,
	input wire logic [2:0] wake_sel,
	// Wake levels
	output logic ext_reset_wake,
	output logic irq_wake,
	output logic nonmaskable_irq_pin,
	output logic key_wake_j,
	output logic key_wake_h,
	output logic can_controller_wakeup,
	output logic slow_divided_clock
);
	logic [5:0] lines;

	// One enable every second clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slow_divided_clock <= 1'b0;
		end else begin
			slow_divided_clock <= !slow_divided_clock;
		end
	end

	// Wake held until the bench sees the core run
	assign lines = wake_on ? (6'h01 << wake_sel) : 6'h00;
	assign {can_controller_wakeup, key_wake_h, key_wake_j} = lines[5:3];
	assign {nonmaskable_irq_pin, irq_wake, ext_reset_wake} = lines[2:0];
endmodule

// File: slh_sequencer_test.sv
// Self-checking bench for the stop exit sequencer.
// Assumes the checker bind and the wake model are compiled alongside.
`timescale 1ns/10ps
module slh_sequencer_test;
	import slh_pkg::*;
	logic clk = 0, rstn = 0, stop_exec = 0, ext_clock_present = 1, wake_on = 0;
	logic [2:0] wake_sel = 0;
	logic ext_reset_wake, irq_wake, nonmaskable_irq_pin, key_wake_j, key_wake_h;
	logic can_controller_wakeup, slow_divided_clock, core_release, core_clock_source;
	logic osc_enable, clock_monitor_reset, monitor_active, pll_bus_clock_select;
	logic module_clock_select, limp_home_irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int failures = 0, compares = 0, n;

	slh_sequencer i_slh_sequencer (.*);
	slh_wake_model i_slh_wake_model (.*);

	always #2 clk = ~clk;

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task summarize;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 0;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awready & s_axi_awvalid;
			tw = s_axi_wready & s_axi_wvalid;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
		@(negedge clk);
	endtask

	task rd(input logic [7:0] a);
		logic ta, tv;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tv = 0;
		while (!tv) begin
			@(negedge clk);
			ta = s_axi_arready & s_axi_arvalid;
			tv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tv) s_axi_rready <= 1'b0;
		end
		@(negedge clk);
	endtask

	// Counts slow enables until release, or until the external clock is used
	task wait_for(input bit to_ext, output int cnt);
		cnt = 0;
		for (int c = 0; c < 40000; c++) begin
			@(negedge clk);
			if (to_ext ? core_clock_source === 1'b0 : core_release === 1'b1) break;
			if (slow_divided_clock) cnt++;
		end
	endtask

	task stop_wake(input logic [7:0] ctl, input logic [2:0] src);
		wr(SLH_CTRL_OFS, {24'h0, ctl});
		@(posedge clk);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		repeat (4) @(negedge clk);
		chk("stopped", 0, core_release);
		chk("osc_enable", ctl[4], osc_enable);
		rd(SLH_STAT_OFS);
		chk("stat_stopped", {29'h0, ctl[4], 2'b01}, d);
		@(posedge clk);
		wake_sel <= src;
		wake_on <= 1'b1;
		wait_for(0, n);
		@(posedge clk);
		wake_on <= 1'b0;
		repeat (2) @(negedge clk);
	endtask

	function logic near(input int got, input int exp);
		return got >= exp - 1 && got <= exp + 2;
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		wr(8'h0c, 32'hff);
		chk("unmapped_bresp", SLH_RESP_SLVERR, r);
		rd(SLH_CTRL_OFS);
		chk("ctrl_reset", SLH_CTRL_RESET, d);
		rd(8'h0c);
		chk("unmapped_resp", SLH_RESP_SLVERR, r);
		chk("unmapped_data", 0, d);
	endtask

	task t_monitor_reset;
		logic seen;
		for (int i = 0; i < 2; i++) begin
			wr(SLH_CTRL_OFS, i ? 32'h05 : 32'h03);
			chk("ctrl_bresp", SLH_RESP_OKAY, r);
			@(posedge clk);
			stop_exec <= 1'b1;
			@(posedge clk);
			stop_exec <= 1'b0;
			seen = 0;
			repeat (6) @(negedge clk) seen |= clock_monitor_reset;
			chk("monitor_reset", 1, seen);
		end
	endtask

	task t_wakes;
		for (int s = 0; s < 6; s++) begin
			stop_wake(8'h00, s[2:0]);
			chk("fast_exit", 1, n <= 3);
			chk("fast_src", 0, core_clock_source);
		end
		rd(SLH_FLAGS_OFS);
		chk("no_limp", 0, d[0]);
	endtask

	task t_delays;
		stop_wake(8'h09, 3'd1);
		chk("stop_delay", 1, near(n, 4096));
		chk("stop_src", 0, core_clock_source);
		stop_wake(8'h18, 3'd2);
		chk("pseudo_limp", 1, near(n, 4096));
		stop_wake(8'h19, 3'd3);
		chk("pseudo_delay", 1, near(n, 4096));
		stop_wake(8'h11, 3'd4);
		chk("pseudo_short", 1, near(n, 16));
	endtask

	task t_limp(input logic [7:0] ctl, input int exp);
		@(posedge clk);
		ext_clock_present <= 1'b0;
		stop_wake(ctl, 3'd5);
		chk("limp_exit", 1, exp ? near(n, exp) : n <= 3);
		chk("limp_src", 1, core_clock_source);
		chk("limp_mon", 1, monitor_active);
		chk("limp_bus", 1, pll_bus_clock_select);
		rd(SLH_FLAGS_OFS);
		chk("limp_flags", 3, d[1:0]);
		chk("limp_irq", ctl[5], limp_home_irq);
		wr(SLH_FLAGS_OFS, 32'h0);
		rd(SLH_FLAGS_OFS);
		chk("flag_kept", 3, d[1:0]);
		wr(SLH_FLAGS_OFS, 32'h2);
		rd(SLH_FLAGS_OFS);
		chk("flag_clear", 1, d[1:0]);
		wr(SLH_CTRL_OFS, {24'h0, ctl & 8'hbf});
		@(posedge clk);
		ext_clock_present <= 1'b1;
		wait_for(1, n);
		chk("recheck", 1, n <= 8196);
		rd(SLH_FLAGS_OFS);
		chk("back_flags", 2, d[1:0]);
		chk("back_irq", ctl[5], limp_home_irq);
		chk("back_bus", 0, pll_bus_clock_select);
		chk("back_mod", ctl[7], module_clock_select);
		wr(SLH_FLAGS_OFS, 32'h2);
	endtask

	initial begin
		#(90000 * 4);
		failures++;
		summarize;
	end

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_monitor_reset;
		t_wakes;
		t_delays;
		t_limp(8'he8, 4096);
		t_limp(8'h40, 0);
		summarize;
	end
endmodule
